// >>> eif_pkg.sv
// package for the external interrupt noise-filter and edge front end
package eif_pkg;
    localparam int          N_IRQ        = 5;
    localparam int          CNT_W        = 7;
    // register indices; byte address is four times the index
    localparam logic [7:0]  CTRL_IDX     = 8'h37;
    localparam logic [7:0]  STAT_IDX     = 8'h38;
    localparam logic [7:0]  MASK_IDX     = 8'h39;
    localparam logic [7:0]  CFG_IDX      = 8'h3A;
    localparam logic [7:0]  LEVEL_IDX    = 8'h3B;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [4:0]  MASK_RST     = 5'h00;
    localparam logic        CFG_RST      = 1'b0;
    // control register field positions; SSS_POS is the bit in the config register
    localparam int          NTS_POS      = 7;
    localparam int          PFS_POS      = 6;
    localparam int          ESC_POS      = 4;
    localparam int          ESD_POS      = 2;
    localparam int          ESB_POS      = 1;
    localparam int          SSS_POS      = 0;
    // pin order within vectors
    localparam int          PIN_A        = 0;
    localparam int          PIN_B        = 1;
    localparam int          PIN_C        = 2;
    localparam int          PIN_D        = 3;
    localparam int          PIN_E        = 4;
    // reject windows in fc periods; fc is clk_i, one period per cycle
    localparam int          FC_PER_CYC   = 1;
    localparam int          REJ_AE_FC    = 2;
    localparam int          REJ_B_LONG   = 63;
    localparam int          REJ_B_SHORT  = 15;
    localparam int          REJ_CD_FC    = 7;
    // in low-speed modes: reject under 1 fs, accept from 3.5 fs
    localparam int          REJ_SLOW_FS  = 2;
    localparam logic [CNT_W-1:0] LEN_AE  = CNT_W'(REJ_AE_FC * FC_PER_CYC);
    localparam logic [CNT_W-1:0] LEN_BL  = CNT_W'(REJ_B_LONG * FC_PER_CYC);
    localparam logic [CNT_W-1:0] LEN_BS  = CNT_W'(REJ_B_SHORT * FC_PER_CYC);
    localparam logic [CNT_W-1:0] LEN_CD  = CNT_W'(REJ_CD_FC * FC_PER_CYC);
    localparam logic [CNT_W-1:0] LEN_SL  = CNT_W'(REJ_SLOW_FS);

    typedef enum logic [1:0] {
        EIF_RISE  = 2'b00,
        EIF_FALL  = 2'b01,
        EIF_BOTH  = 2'b10,
        EIF_HIGH  = 2'b11
    } eif_edge_e;

    typedef struct packed {
        logic       noise_time_select;
        logic       pin_function_select;
        eif_edge_e  edge_select_c;
        eif_edge_e  edge_select_d;
        logic       edge_select_b;
        logic       unused0;
    } eif_ctrl_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [9:0]  adr;
        logic [31:0] dat;
    } eif_wb_req_s;
endpackage

// >>> eif_top.sv
// external interrupt front end: pin sync, noise filters, edge/level detect, latches
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
module eif_top
    import eif_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [9:0]        wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [N_IRQ-1:0]  ext_irq_i,
    input  wire logic              low_speed_i,
    input  wire logic              fs_tick_i,
    input  wire logic [N_IRQ-1:0]  irq_accept_i,
    output logic      [N_IRQ-1:0]  latch_irq_o,
    output logic                   shared_port_bit_o,
    output logic                   irq_o
);
    // filter length per pin, in steps of the active filter clock
    function automatic logic [CNT_W-1:0] flt_len(input int idx, input logic nts,
                                                 input logic slow);
        logic [CNT_W-1:0] len;
        len = LEN_CD;
        if (slow) begin
            len = LEN_SL;
        end else if (idx == PIN_A || idx == PIN_E) begin
            len = LEN_AE;
        end else if (idx == PIN_B) begin
            len = nts ? LEN_BS : LEN_BL;
        end
        return len;
    endfunction

    function automatic logic edge_hit(input eif_edge_e es, input logic rise,
                                      input logic fall, input logic lvl);
        logic hit;
        case (es)
            EIF_RISE: hit = rise;
            EIF_FALL: hit = fall;
            EIF_BOTH: hit = rise | fall;
            EIF_HIGH: hit = lvl;
            default:  hit = 1'b0;
        endcase
        return hit;
    endfunction

    eif_wb_req_s             req;
    eif_ctrl_s               ctrl_q;
    logic [N_IRQ-1:0]        mask_q;
    logic                    sss_q;
    logic [N_IRQ-1:0]        lat_q;
    logic [N_IRQ-1:0]        lat_d;
    logic [N_IRQ-1:0]        s1_q;
    logic [N_IRQ-1:0]        s2_q;
    logic [N_IRQ-1:0]        s3_q;
    logic [N_IRQ-1:0]        samp_q;
    logic [N_IRQ-1:0]        filt_q;
    logic [N_IRQ-1:0]        prev_q;
    logic [N_IRQ-1:0]        prim_q;
    logic [N_IRQ-1:0]        pprim_q;
    logic [N_IRQ-1:0]        armed_q;
    logic [CNT_W-1:0]        cnt_q [N_IRQ];
    logic [31:0]             rdat_d;
    logic                    ack_q;
    logic                    irq_q;

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                   adr: wb_adr_i, dat: wb_dat_i};

    // bus decode; writes take effect on the edge where ack is seen high
    wire       acc_w   = req.cyc & req.stb;
    wire [7:0] idx_w   = req.adr[9:2];
    wire       wr_w    = acc_w & req.we & ack_q & req.sel[0];
    wire       wr_ctl  = wr_w & (idx_w == CTRL_IDX);
    wire       wr_stat = wr_w & (idx_w == STAT_IDX);
    wire       wr_mask = wr_w & (idx_w == MASK_IDX);
    wire       wr_cfg  = wr_w & (idx_w == CFG_IDX);

    // filter steps every fc cycle, or only on fs ticks in low-speed modes
    wire       step_w  = low_speed_i ? fs_tick_i : 1'b1;

    wire [N_IRQ-1:0] rise_w = filt_q & ~prev_q & pprim_q;
    wire [N_IRQ-1:0] fall_w = ~filt_q & prev_q & pprim_q;

    // level mode waits for a rising edge, so a pin already high at reset stays quiet
    wire [N_IRQ-1:0] lvl_w  = filt_q & armed_q;

    wire [N_IRQ-1:0] set_w;
    assign set_w[PIN_A] = fall_w[PIN_A] & ctrl_q.pin_function_select;
    assign set_w[PIN_B] = ctrl_q.edge_select_b ? fall_w[PIN_B] : rise_w[PIN_B];
    assign set_w[PIN_C] = sss_q & edge_hit(ctrl_q.edge_select_c, rise_w[PIN_C],
                                           fall_w[PIN_C], lvl_w[PIN_C]);
    assign set_w[PIN_D] = edge_hit(ctrl_q.edge_select_d, rise_w[PIN_D],
                                   fall_w[PIN_D], lvl_w[PIN_D]);
    assign set_w[PIN_E] = fall_w[PIN_E];

    // a new event in the clearing cycle wins over the clear
    wire [N_IRQ-1:0] clr_w = irq_accept_i | (wr_stat ? req.dat[N_IRQ-1:0] : '0);
    assign lat_d = (lat_q & ~clr_w) | set_w;

    always_comb begin
        rdat_d = 32'h0000_0000;
        case (idx_w)
            CTRL_IDX:  rdat_d[7:0] = ctrl_q;
            STAT_IDX:  rdat_d[N_IRQ-1:0] = lat_q;
            MASK_IDX:  rdat_d[N_IRQ-1:0] = mask_q;
            CFG_IDX:   rdat_d[SSS_POS] = sss_q;
            LEVEL_IDX: rdat_d[N_IRQ-1:0] = filt_q;
            default:   rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q    <= acc_w & ~ack_q;
            wb_dat_o <= (acc_w & ~ack_q) ? rdat_d : wb_dat_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= eif_ctrl_s'(CTRL_RST);
            mask_q <= MASK_RST;
            sss_q  <= CFG_RST;
        end else begin
            // new select bits reach the filter on the next cycle
            if (wr_ctl) begin
                ctrl_q <= eif_ctrl_s'(req.dat[7:0]);
            end
            if (wr_mask) begin
                mask_q <= req.dat[N_IRQ-1:0];
            end
            if (wr_cfg) begin
                sss_q <= req.dat[SSS_POS];
            end
        end
    end

    // three-stage synchroniser; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            samp_q <= '0;
        end else begin
            s1_q   <= ext_irq_i;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            samp_q <= (s2_q ~^ s3_q) & s3_q | (s2_q ^ s3_q) & samp_q;
        end
    end

    wire [N_IRQ-1:0] busy_w;
    wire [N_IRQ-1:0] pass_w;
    wire [CNT_W-1:0] len_w     [N_IRQ];
    wire [CNT_W-1:0] cnt_inc_w [N_IRQ];
    wire [CNT_W-1:0] cnt_d     [N_IRQ];

    // a pin that has not primed keeps counting even while its level agrees
    for (genvar g = 0; g < N_IRQ; g++) begin : g_flt
        assign busy_w[g]    = (samp_q[g] != filt_q[g]) | ~prim_q[g];
        assign len_w[g]     = flt_len(g, ctrl_q.noise_time_select, low_speed_i);
        assign cnt_inc_w[g] = cnt_q[g] + 1'b1;
        assign pass_w[g]    = busy_w[g] & step_w & (cnt_inc_w[g] >= len_w[g]);
        assign cnt_d[g]     = (!busy_w[g] || pass_w[g]) ? '0 :
                              (step_w ? cnt_inc_w[g] : cnt_q[g]);
    end

    // per-pin filter: level must hold for the window length before it is passed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_q  <= '0;
            prev_q  <= '0;
            prim_q  <= '0;
            pprim_q <= '0;
            armed_q <= '0;
            for (int i = 0; i < N_IRQ; i++) begin
                cnt_q[i] <= '0;
            end
        end else begin
            prev_q  <= filt_q;
            pprim_q <= prim_q;
            armed_q <= armed_q | rise_w;
            // first settled level after reset only primes, no edge
            filt_q  <= (filt_q & ~pass_w) | (samp_q & pass_w);
            prim_q  <= prim_q | pass_w;
            for (int i = 0; i < N_IRQ; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
        end
    end

    // latch adds one cycle after the filter and irq_o one more, well inside six fs periods
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_q             <= '0;
            irq_q             <= 1'b0;
            shared_port_bit_o <= 1'b0;
        end else begin
            lat_q             <= lat_d;
            irq_q             <= |(lat_q & mask_q);
            shared_port_bit_o <= ctrl_q.pin_function_select ? 1'b0 : samp_q[PIN_A];
        end
    end

    assign wb_ack_o    = ack_q;
    assign latch_irq_o = lat_q;
    assign irq_o       = irq_q;
endmodule // eif_top

// >>> eif_pin_src.sv
// far-side model: five external pin sources
`timescale 1ns/10ps
module eif_pin_src (
    input  wire logic       clk_i,
    input  wire logic [4:0] want_i,
    output logic      [4:0] pin_o
);
    // one flop per pin so every source moves on its own
    always_ff @(posedge clk_i) begin
        pin_o <= want_i;
    end
endmodule // eif_pin_src

// >>> eif_top_sva.sv
// port assertions for the external interrupt front end
`timescale 1ns/10ps
module eif_sva
    import eif_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [9:0]       wb_adr_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic [N_IRQ-1:0] ext_irq_i,
    input wire logic             low_speed_i,
    input wire logic             fs_tick_i,
    input wire logic [N_IRQ-1:0] irq_accept_i,
    input wire logic [N_IRQ-1:0] latch_irq_o,
    input wire logic             shared_port_bit_o,
    input wire logic             irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_latch_hold: assert property ((($past(latch_irq_o) & ~latch_irq_o) != 5'h0)
        |-> ($past(irq_accept_i) != 5'h0) || $past(wb_we_i && wb_ack_o))
        else $error("latch dropped without clear");
    a_irq_cause: assert property (irq_o |-> $past(latch_irq_o) != 5'h0)
        else $error("irq without latch");
    a_filter_pin_a: assert property ($rose(latch_irq_o[0]) && !low_speed_i
        |-> !$past(ext_irq_i[0], 7) && !$past(ext_irq_i[0], 6)) else $error("pin a pulse");
    a_filter_pin_e: assert property ($rose(latch_irq_o[4]) && !low_speed_i
        |-> !$past(ext_irq_i[4], 7) && !$past(ext_irq_i[4], 6)) else $error("pin e pulse");
    a_reset_clear: assert property (disable iff (1'b0) rst_i |=> latch_irq_o == 5'h0
        && !irq_o && !wb_ack_o && !shared_port_bit_o) else $error("outputs set in reset");
    c_latch_a: cover property ($rose(latch_irq_o[0]));
    c_latch_c: cover property ($rose(latch_irq_o[2]));
    c_irq: cover property ($rose(irq_o));
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule // eif_sva
bind eif_top eif_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_irq_i(ext_irq_i),
    .low_speed_i(low_speed_i), .fs_tick_i(fs_tick_i), .irq_accept_i(irq_accept_i),
    .latch_irq_o(latch_irq_o), .shared_port_bit_o(shared_port_bit_o), .irq_o(irq_o));

// >>> ext_irq_noise_edge_front_end_tb.sv
// self-checking testbench for the external interrupt front end
`timescale 1ns/10ps
module ext_irq_noise_edge_front_end_tb;
    import eif_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, low_speed_i, fs_tick_i, ack, irq_o, port_o;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [2:0]  div;
    logic [31:0] wdat, dat_o, rd;
    logic [4:0]  want, pins, accept, lat;
    int          fails, samples_checked;
    eif_pin_src src (.clk_i(clk_i), .want_i(want), .pin_o(pins));
    eif_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ext_irq_i(pins), .low_speed_i(low_speed_i), .fs_tick_i(fs_tick_i),
        .irq_accept_i(accept), .latch_irq_o(lat), .shared_port_bit_o(port_o), .irq_o(irq_o));
    initial begin
        clk_i = 0;
        forever #2 clk_i = ~clk_i;
    end
    // fs runs at one eighth of fc so one fs period spans several filter samples
    always @(posedge clk_i) begin
        if (rst_i) begin
            div       <= 3'h0;
            fs_tick_i <= 1'b0;
        end else begin
            div       <= div + 3'h1;
            fs_tick_i <= low_speed_i && (div == 3'h7);
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wb(logic w, logic [7:0] idx, logic [7:0] d);
        int i;
        cyc <= 1; stb <= 1; we <= w; sel <= 4'hf; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
        i = 0;
        do begin @(posedge clk_i); i++; end while (ack !== 1'b1 && i < 20);
        if (i >= 20) begin fails++; end_of_test(); end
        rd = dat_o;
        cyc <= 0; stb <= 0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic wl(string n, int b, int lim, logic e);
        int i;
        for (i = 0; i < lim && lat[b] !== 1'b1; i++) @(posedge clk_i);
        chk(n, e, lat[b]);
        if (e && lat[b] !== 1'b1) end_of_test();
    endtask
    task automatic pls(int b, logic v, int n);
        want[b] <= v;
        repeat (n) @(posedge clk_i);
        want[b] <= ~v;
    endtask
    task automatic acc(logic [4:0] m);
        accept <= m; @(posedge clk_i); accept <= 5'h0; repeat (2) @(posedge clk_i);
    endtask
    task automatic t_regs();
        wb(0, CTRL_IDX, 0); chk("ctrl reset", CTRL_RST, rd);
        wb(0, MASK_IDX, 0); chk("mask reset", MASK_RST, rd);
        wb(0, CFG_IDX, 0); chk("cfg reset", CFG_RST, rd);
        wb(0, 8'h3F, 0); chk("unmapped", 0, rd);
        wb(1, CTRL_IDX, 8'h5A); wb(0, CTRL_IDX, 0); chk("ctrl rw", 8'h5A, rd);
    endtask
    task automatic t_level_reset();
        wb(1, CTRL_IDX, 8'h0C); repeat (30) @(posedge clk_i);
        chk("d high at release", 0, lat[3]);
        pls(3, 0, 20); wl("d high after rise", 3, 40, 1);
        want[3] <= 0;
        repeat (20) @(posedge clk_i);
        wb(0, LEVEL_IDX, 0);
        chk("filtered levels", 8'h11, rd);
        wb(0, STAT_IDX, 0);
        chk("status", 8'h08, rd);
        acc(5'h08);
    endtask
    task automatic t_pin_a();
        wb(1, CTRL_IDX, 8'h00); chk("port bit", 1, port_o);
        pls(0, 0, 12); wl("a as port", 0, 20, 0);
        wb(1, CTRL_IDX, 8'h40); wb(1, MASK_IDX, 8'h01); chk("port off", 0, port_o);
        pls(0, 0, 1); wl("a short", 0, 12, 0);
        want[0] <= 0; wl("a edge", 0, 12, 1); want[0] <= 1;
        @(posedge clk_i); @(posedge clk_i); chk("irq on", 1, irq_o);
        wb(1, MASK_IDX, 8'h00); chk("irq masked", 0, irq_o);
        wb(1, STAT_IDX, 8'h01); chk("a cleared", 0, lat[0]);
    endtask
    task automatic t_pin_b();
        wb(1, CTRL_IDX, 8'h80);
        pls(1, 1, 12); wl("b 15 short", 1, 30, 0);
        pls(1, 1, 20); wl("b 15 long", 1, 30, 1); acc(5'h02);
        wl("b fall ignored", 1, 30, 0);
        wb(1, CTRL_IDX, 8'h00);
        pls(1, 1, 40); wl("b 63 short", 1, 80, 0);
        pls(1, 1, 70); wl("b 63 long", 1, 30, 1); acc(5'h02);
    endtask
    task automatic t_modes();
        pls(2, 1, 30); wl("c unselected", 2, 30, 0);
        wb(1, CFG_IDX, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wb(1, CTRL_IDX, 8'((m << ESC_POS) | (m << ESD_POS)));
            want[2] <= 1;
            want[3] <= 1;
            wl("c rise side", 2, 40, m != 1);
            chk("d rise side", m != 1, lat[3]);
            acc(5'h0C);
            want[2] <= 0;
            want[3] <= 0;
            wl("c fall side", 2, 40, m != 0);
            chk("d fall side", m != 0, lat[3]);
            // level mode re-sets the latch until the filtered level has dropped
            repeat (16) @(posedge clk_i);
            acc(5'h0C);
        end
        pls(2, 1, 5); wl("c short", 2, 30, 0);
    endtask
    task automatic t_pin_e();
        want[4] <= 0; wl("e fast", 4, 12, 1); want[4] <= 1; acc(5'h10);
        low_speed_i <= 1;
        pls(4, 0, 4); wl("e slow short", 4, 40, 0);
        pls(4, 0, 40); wl("e slow long", 4, 40, 1);
        low_speed_i <= 0;
    endtask
    initial begin
        rst_i = 1; cyc = 0; stb = 0; we = 0; sel = 0; adr = 0; wdat = 0;
        low_speed_i = 0; want = 5'b11001; accept = 0;
        fails = 0; samples_checked = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs(); t_level_reset(); t_pin_a(); t_pin_b(); t_modes(); t_pin_e();
        end_of_test();
    end
endmodule // ext_irq_noise_edge_front_end_tb
